// ---- bdc_map.svh ----
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH
// count layout
`define BDC_COUNT_WIDTH 16
`define BDC_STAGE_WIDTH 8
`define BDC_UPPER_MSB 15
`define BDC_UPPER_LSB 8
`define BDC_LOWER_MSB 7
`define BDC_LOWER_LSB 0
// reset value and terminal values of one stage
`define BDC_STAGE_RESET 8'h00
`define BDC_STAGE_MIN 8'h00
`define BDC_STAGE_MAX 8'hFF
`endif

// ---- bdc_pkg.sv ----
`default_nettype none
package bdc_pkg;
	typedef logic [7:0] bdc_stage_t;
	typedef logic [15:0] bdc_count_t;
	// one-hot state of the pulse edge tracker
	typedef enum logic [1:0] {
		BDC_IDLE = 2'b01,
		BDC_HIGH = 2'b10
	} bdc_edge_t;
endpackage
`default_nettype wire

// ---- bdc_stage_if.sv ----
`default_nettype none
interface bdc_stage_if;
	logic step;
	logic countUp;
	logic hold;
	logic clear;
	logic [7:0] value;
	logic terminal;
	modport stage (input step, countUp, hold, clear, output value, terminal);
	modport ctrl (output step, countUp, hold, clear, input value, terminal);
endinterface
`default_nettype wire

// ---- bdc_count_stage.sv ----
`include "bdc_map.svh"
`default_nettype none
module bdc_count_stage (
	input wire logic mclk,
	input wire logic rstn,
	bdc_stage_if.stage link
);
	import bdc_pkg::*;

	// next value of one stage, wrapping both ways
	function automatic bdc_stage_t stepValue(input bdc_stage_t v, input logic up);
		stepValue = up ? bdc_stage_t'(v + 8'h01) : bdc_stage_t'(v - 8'h01);
	endfunction

	bdc_stage_t count;

	// stage register: clear first, then hold, then step
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count <= `BDC_STAGE_RESET;
		end else if (link.clear) begin
			count <= `BDC_STAGE_RESET;
		end else if (link.step && !link.hold) begin
			count <= stepValue(count, link.countUp);
		end
	end

	// terminal flag: 0 going down, 255 going up
	assign link.terminal = link.countUp ? (count == `BDC_STAGE_MAX)
		: (count == `BDC_STAGE_MIN);
	assign link.value = count;
endmodule // bdc_count_stage
`default_nettype wire

// ---- bdc_counter.sv ----
`include "bdc_map.svh"
`default_nettype none
module bdc_counter #(
	parameter int COUNT_WIDTH = `BDC_COUNT_WIDTH,
	parameter int STAGE_WIDTH = `BDC_STAGE_WIDTH
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic pulseIn,
	input wire logic countUp,
	input wire logic genReset,
	output logic [15:0] countValue,
	output logic lowerTerminal
);
	import bdc_pkg::*;

	////////////////////////////////////////////////////////////////
	// block overview
	//
	// the pulse pin, the direction pin and the general reset pin all come
	// from outside the clock domain, so each passes two flops first
	//
	// a rising edge of the synchronised pulse gives a one-cycle step that
	// both stages see together; the upper stage is held unless the lower
	// stage sits at its terminal value for the present direction
	//
	// latency from a pulse pin edge to the readout port is four clocks:
	// two for the synchroniser, one for the stage and one for the readout
	//
	// a direction change should settle two clocks before a pulse edge,
	// otherwise the pulse may count with either direction
	//
	// the general reset wins over a step that falls in the same clock

	////////////////////////////////////////////////////////////////
	// elaboration checks
	// the readout port and the package types are built for two 8-bit
	// stages; any other split would silently lose count bits
	generate
		if (COUNT_WIDTH != 16) begin : gBadCount
			$error("count width must be 16");
		end
		if (STAGE_WIDTH != 8) begin : gBadStage
			$error("stage width must be 8");
		end
		if (COUNT_WIDTH != 2 * STAGE_WIDTH) begin : gBadSplit
			$error("count must be two stages");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] pulseSync;
	logic [1:0] upSync;
	logic [1:0] resetSync;

	// two flops on the pulse pin
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pulseSync <= 2'h0; // idle low, so no false edge after reset
		end else begin
			pulseSync <= {pulseSync[0], pulseIn};
		end
	end

	// two flops on the direction pin
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			upSync <= 2'h0;
		end else begin
			upSync <= {upSync[0], countUp};
		end
	end

	// two flops on the general reset pin
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			resetSync <= 2'h0;
		end else begin
			resetSync <= {resetSync[0], genReset};
		end
	end

	////////////////////////////////////////////////////////////////
	// pulse rising edge tracker
	bdc_edge_t edgeState;
	bdc_edge_t next_edgeState;
	logic step;

	always_comb begin
		next_edgeState = edgeState;
		step = 1'b0;
		case (edgeState)
			BDC_IDLE: begin
				if (pulseSync[1]) begin
					next_edgeState = BDC_HIGH;
					step = 1'b1;
				end
			end
			BDC_HIGH: begin
				if (!pulseSync[1]) begin
					next_edgeState = BDC_IDLE;
				end
			end
			default: begin
				next_edgeState = BDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			edgeState <= BDC_IDLE;
		end else begin
			edgeState <= next_edgeState;
		end
	end

	////////////////////////////////////////////////////////////////
	// the two stages
	bdc_stage_if upperLink ();
	bdc_stage_if lowerLink ();

	// both stages see the same step, direction and clear
	assign lowerLink.step = step;
	assign lowerLink.countUp = upSync[1];
	assign lowerLink.hold = 1'b0;
	assign lowerLink.clear = resetSync[1];
	assign upperLink.step = step;
	assign upperLink.countUp = upSync[1];
	assign upperLink.hold = ~lowerLink.terminal;
	assign upperLink.clear = resetSync[1];

	bdc_count_stage upperCountStage (
		.mclk(mclk),
		.rstn(rstn),
		.link(upperLink.stage)
	);

	bdc_count_stage lowerCountStage (
		.mclk(mclk),
		.rstn(rstn),
		.link(lowerLink.stage)
	);

	////////////////////////////////////////////////////////////////
	// registered readout of the combined value
	//
	// the host may sample the port at any clock; the value is the stage
	// contents one clock after they change, so it never shows a half carry

	// combined count, upper stage in the high byte
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			countValue <= 16'h0000;
		end else begin
			countValue <= {upperLink.value, lowerLink.value};
		end
	end

	// lower terminal flag, registered in step with the count
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lowerTerminal <= 1'b0;
		end else begin
			lowerTerminal <= lowerLink.terminal;
		end
	end
endmodule // bdc_counter
`default_nettype wire

// ---- bdc_counter_checker.sv ----
`default_nettype none
module bdc_counter_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic pulseIn,
	input wire logic countUp,
	input wire logic genReset,
	input wire logic [15:0] countValue,
	input wire logic lowerTerminal
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [15:0] cv;
	assign cv = countValue;
	// a pulse held high must reach the count
	sequence s_edge; $rose(pulseIn) ##1 (pulseIn && !genReset)[*2]; endsequence
	chk_step_seen: assert property (s_edge |-> ##[0:5] $changed(cv)) else $error("lost");
	chk_step_size: assert property ($changed(cv) |-> cv == 16'h0 ||
		cv == $past(cv) + 16'h1 || cv == $past(cv) - 16'h1) else $error("jump");
	chk_upper_hold: assert property ($changed(cv[15:8]) |-> cv == 16'h0 ||
		$past(cv[7:0]) inside {8'h00, 8'hFF}) else $error("carry");
	chk_count_up: assert property ($changed(cv) && cv != 16'h0 &&
		$past(countUp, 3) && $past(countUp, 6) |-> cv == $past(cv) + 16'h1) else $error("up");
	chk_count_down: assert property ($changed(cv) && cv != 16'h0 &&
		!$past(countUp, 3) && !$past(countUp, 6) |-> cv == $past(cv) - 16'h1)
		else $error("down");
	chk_term_flag: assert property (lowerTerminal |->
		cv[7:0] inside {8'h00, 8'hFF} || $past(cv[7:0]) inside {8'h00, 8'hFF})
		else $error("flag");
	chk_clear_all: assert property (genReset[*7] |-> cv == 16'h0) else $error("clear");
	chk_idle_stable: assert property ((!pulseIn && !genReset)[*6] |=> $stable(cv))
		else $error("drift");
endmodule // bdc_counter_checker
bind bdc_counter bdc_counter_checker bdc_counter_checker_inst (.mclk(mclk), .rstn(rstn),
	.pulseIn(pulseIn), .countUp(countUp), .genReset(genReset), .countValue(countValue),
	.lowerTerminal(lowerTerminal));
`default_nettype wire

// ---- bdc_pulse_src.sv ----
`default_nettype none
module bdc_pulse_src (
	input wire logic mclk,
	input wire logic burst,
	output logic pulseIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ph = 3'h0;
	// 3 high then 3 low per pulse, finishing a pulse once begun
	always_ff @(posedge mclk) ph <= (burst || ph != 3'h0) ? ((ph == 3'h5) ? 3'h0 : ph + 3'h1) : 3'h0;
	assign pulseIn = ph >= 3'h1 && ph <= 3'h3;
endmodule // bdc_pulse_src
`default_nettype wire

// ---- tb_bdc_counter.sv ----
`default_nettype none
module tb_bdc_counter;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rstn = 0, countUp = 1, genReset = 0, burst = 0, pulseIn, lowerTerminal;
	logic [15:0] countValue;
	int errTotal = 0, checksDone = 0, cyc = 0;
	bdc_counter bdc_counter_inst (.mclk(mclk), .rstn(rstn), .pulseIn(pulseIn),
		.countUp(countUp), .genReset(genReset), .countValue(countValue),
		.lowerTerminal(lowerTerminal));
	bdc_pulse_src bdc_pulse_src_inst (.mclk(mclk), .burst(burst), .pulseIn(pulseIn));
	initial forever #25 mclk = ~mclk;
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [16:0] exp);
		checksDone++;
		if ({lowerTerminal, countValue} !== exp) begin
			errTotal++;
			$display("BAD %0t got %h", $time, {lowerTerminal, countValue});
		end
	endtask
	task automatic pulses(input int n);
		burst = 1;
		tick(6 * n);
		burst = 0;
		tick(9);
	endtask
	// carry into the upper stage at lower 255
	task automatic t_up;
		pulses(255);
		chk({1'b1, 16'h00FF});
		pulses(2);
		chk({1'b0, 16'h0101});
	endtask
	// borrow through zero and wrap
	task automatic t_down;
		countUp = 0;
		tick(4);
		pulses(258);
		chk({1'b0, 16'hFFFF});
	endtask
	task automatic t_clear;
		genReset = 1;
		tick(8);
		genReset = 0;
		tick(3);
		chk({1'b1, 16'h0000});
	endtask
	task automatic close_out;
		if (errTotal == 0 && checksDone > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			errTotal++;
			close_out;
		end
	end
	initial begin
		tick(3);
		rstn = 1;
		tick(3);
		chk({1'b0, 16'h0000});
		t_up;
		t_down;
		t_clear;
		close_out;
	end
endmodule // tb_bdc_counter
`default_nettype wire
